// ===== dai_delay_timer.sv
`timescale 1ns/1ps
module dai_delay_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  logic         pclk,
  input  logic         presetn,
  // Timing
  input  logic         tick,
  input  logic [W-1:0] on_dly,
  input  logic [W-1:0] off_dly,
  // Signal
  input  logic         din,
  output logic         dout_q
);
  logic [W-1:0] cnt_q;
  wire  [W-1:0] dly    = dout_q ? off_dly : on_dly;
  wire  [W-1:0] cnt_nx = cnt_q + 1'b1;
  wire          expire = (dly == '0) || (tick && cnt_nx >= dly);

  // A flip back before expiry restarts the count from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      dout_q <= 1'b0;
    end else if (din == dout_q) begin
      cnt_q <= '0; // see R25
    end else if (expire) begin
      cnt_q  <= '0;
      dout_q <= din; // see R10 see R11
    end else if (tick) begin
      cnt_q <= cnt_nx;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_on_after_hold: assert property ( // see R10
    $rose(dout_q) |-> $past(din) && (on_dly == '0 || $past(tick)))
    else $error("timer output rose without a held input");
  a_off_after_hold: assert property ( // see R11
    $fell(dout_q) |-> !$past(din) && (off_dly == '0 || $past(tick)))
    else $error("timer output fell without a held release");
endmodule // dai_delay_timer

// ===== dai_lpf.sv
`timescale 1ns/1ps
module dai_lpf #(
  parameter int STEP_CYC = 31250,
  parameter int TW       = 8
) (
  // Clock and reset
  input  logic                pclk,
  input  logic                presetn,
  // Filter
  input  logic [TW-1:0]       tau,
  input  logic signed [15:0]  x,
  output logic signed [15:0]  y
);
  import dai_pkg::*;
  logic signed [19:0] acc_q;
  logic [31:0]        cnt_q;
  wire  [31:0] step_len = 32'(tau) * 32'(STEP_CYC);
  wire         step     = (cnt_q + 32'h1) >= step_len;
  wire signed [20:0] diff = 21'($signed({x, 4'h0})) - 21'(acc_q);

  // One sixteenth of the gap per step gives about 63 % after tau
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      cnt_q <= '0;
    end else if (tau == '0) begin
      acc_q <= $signed({x, 4'h0});
      cnt_q <= '0;
    end else if (step) begin
      acc_q <= acc_q + 20'(diff >>> FILT_SHIFT); // see R22
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign y = acc_q[19:4];
endmodule // dai_lpf

// ===== dai_pgen.sv
`timescale 1ns/1ps
module dai_pgen (
  // Clock and control
  input  logic pclk,
  input  logic en,
  // Pulse pin
  output logic pin
);
  logic [1:0] cnt_q = 2'h0;
  // One high clock in four; the line idles low while disabled
  always_ff @(posedge pclk) begin
    cnt_q <= en ? cnt_q + 2'h1 : 2'h0;
    pin   <= en && cnt_q == 2'h0;
  end
endmodule // dai_pgen

// ===== dai_pkg.sv
package dai_pkg;
  localparam int CLK_HZ = 50_000_000;
  // Time bases of the delay timers
  localparam int TICK_SLOW_MS  = 100;
  localparam int TICK_FAST_MS  = 10;
  localparam int TICK_SLOW_CYC = TICK_SLOW_MS * (CLK_HZ / 1000);
  localparam int TICK_FAST_CYC = TICK_FAST_MS * (CLK_HZ / 1000);
  // Sixteen filter steps per 10 ms unit of time constant
  localparam int FILT_STEP_US  = 625;
  localparam int FILT_STEP_CYC = FILT_STEP_US * (CLK_HZ / 1_000_000);
  localparam int FILT_SHIFT    = 4;
  // Gate and toggle thresholds in scale-units times clocks
  localparam longint PI_GATE = 64'(CLK_HZ) * 1000;
  localparam longint PO_HALF = 64'(CLK_HZ) * 500;

  localparam logic [2:0] REF_ANALOG  = 3'h1;
  localparam logic [2:0] REF_PULSE   = 3'h4;
  localparam logic [1:0] PI_GENERAL  = 2'h0;
  localparam logic [2:0] PO_FREQ_CMD = 3'h1;
  localparam logic [2:0] PO_OUT_FREQ = 3'h2;
  localparam logic [7:0] MFI_SYNC    = 8'h20;
  localparam logic [7:0] MFI_TIMER   = 8'h23;
  localparam logic [7:0] MFO_TIMER   = 8'h1B;
  localparam logic [4:0] AIN2_AUX    = 5'h00;
  localparam logic [4:0] AIN2_ADD    = 5'h0A;
  localparam logic [4:0] AIN2_THERM  = 5'h11;
  localparam logic signed [15:0] THERM_TRIP = 16'sh1388;

  localparam logic signed [15:0] PCT_MAX  = 16'sh7FFF;
  localparam int                 GAIN_ONE = 1000;
  localparam int                 TRQ_UNIT = 10;
  localparam logic signed [13:0] AIN_FS   = 14'sh0FFF;
  localparam logic signed [13:0] ADC_MID  = 14'sh0800;
  localparam logic signed [13:0] ADC_4MA  = 14'sh0333;
  localparam int                 AIN_QB   = 12;

  localparam int NUM_CFG = 27;
  localparam logic [4:0] IX_REF_SRC  = 5'h00;
  localparam logic [4:0] IX_PI_FUNC  = 5'h01;
  localparam logic [4:0] IX_PI_SCALE = 5'h02;
  localparam logic [4:0] IX_PI_GAIN  = 5'h03;
  localparam logic [4:0] IX_PI_BIAS  = 5'h04;
  localparam logic [4:0] IX_PO_FUNC  = 5'h05;
  localparam logic [4:0] IX_PO_SCALE = 5'h06;
  localparam logic [4:0] IX_MFI0     = 5'h07;
  localparam logic [4:0] IX_MFO_FUNC = 5'h0B;
  localparam logic [4:0] IX_TMR_ON   = 5'h0C;
  localparam logic [4:0] IX_TMR_OFF  = 5'h0D;
  localparam logic [4:0] IX_TRQ_LVL  = 5'h0E;
  localparam logic [4:0] IX_BRK_DLY  = 5'h0F;
  localparam logic [4:0] IX_FDET_LVL = 5'h10;
  localparam logic [4:0] IX_UPDN_SEL = 5'h11;
  localparam logic [4:0] IX_AIN_TYPE = 5'h12;
  localparam logic [4:0] IX_NEG_CHAR = 5'h13;
  localparam logic [4:0] IX_A1_FILT  = 5'h14;
  localparam logic [4:0] IX_A1_GAIN  = 5'h15;
  localparam logic [4:0] IX_A1_BIAS  = 5'h16;
  localparam logic [4:0] IX_A2_FUNC  = 5'h17;
  localparam logic [4:0] IX_A2_FILT  = 5'h18;
  localparam logic [4:0] IX_A2_GAIN  = 5'h19;
  localparam logic [4:0] IX_A2_BIAS  = 5'h1A;
  localparam logic [4:0] IX_STATUS   = 5'h1C;
  localparam logic [4:0] IX_PI_PCT   = 5'h1D;
  localparam logic [4:0] IX_AIN1_PCT = 5'h1E;
  localparam logic [4:0] IX_FREQ_REF = 5'h1F;

  typedef logic signed [16:0] dai_lim_t;
  localparam dai_lim_t CFG_MIN [NUM_CFG] = '{
    0, 0, 10, 0, -1000, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0,
    0, 0, 0, 0, 0, 0, -1000, 0, 0, 0, -1000};
  localparam dai_lim_t CFG_MAX [NUM_CFG] = '{
    7, 3, 32000, 10000, 1000, 7, 32000, 65535, 65535, 65535, 65535,
    255, 60000, 60000, 150, 6500, 32767, 1, 5, 1, 200, 10000, 1000,
    17, 200, 10000, 10000};
  localparam dai_lim_t CFG_RST [NUM_CFG] = '{
    1, 0, 1000, 1000, 0, 2, 1000, 0, 0, 0, 0, 0, 0, 0, 0, 0,
    0, 0, 0, 0, 0, 1000, 0, 0, 0, 1000, 0};
  localparam logic [NUM_CFG-1:0] CFG_SGN = 27'h4400010;

  typedef enum logic [1:0] {AIN_V_UNI, AIN_V_BI, AIN_I_4_20} dai_ain_mode_t;

  typedef struct packed {
    logic therm;
    logic pulse_ok;
    logic brake;
    logic timer;
    logic sync;
  } dai_flags_t;

  function automatic logic signed [15:0] sat_pct(
      input logic signed [47:0] v);
    if (v > 48'sh7FFF) return PCT_MAX;
    if (v < -48'sh7FFF) return -PCT_MAX;
    return v[15:0];
  endfunction
endpackage

// ===== dai_top.sv
// Operation
// R1 - Reference source code 1 takes analog input, code 4 the pulse input
// R2 - Pulse output code 2 follows output frequency; scale equals 100 percent
// R3 - Pulse input function code 0 is general pulse frequency command
// R4 - Pulse input scale in hertz maps to 100 percent reference
// R5 - Scaled pulse input is multiplied by programmable gain
// R6 - Programmable bias is added to gain-scaled pulse input
// R7 - Any of eight inputs with code 32 is the sync command
// R8 - Timer on and off delays span 0 to 6000 s in 0.1 s
// R9 - Timer works only with input code 35 and output code 27
// R10 - Timer output sets after input held on for on-delay
// R11 - Timer output clears after input held off for off-delay
// R12 - Brake releases after delay when running, frequency and torque high
// R13 - Host should pair brake release with start/stop frequency lock
// R14 - Ramp selector picks accel/decel time 1 or 2 for UP/DOWN
// R15 - Six input type codes decode both analog input signal ranges
// R16 - Each analog input has a filter time of 0 to 2 s
// R17 - Each analog input has gain 0 to 1000 percent and a bias
// R18 - Gain is the level at full-scale input
// R19 - Bias is the level at zero-scale input
// R20 - Second input function takes codes 0 to 17, add and thermistor
// R21 - Second input bias spans -100 to 1000 percent
// R22 - Input filters are first order, 63 percent at time constant
// R23 - Negative characteristic reverses the analog reference slope
// R24 - Gain and bias results saturate instead of wrapping
// R25 - Timer counts restart when the input changes before expiry
`timescale 1ns/1ps
module dai_top #(
  parameter int     TICK_SLOW = dai_pkg::TICK_SLOW_CYC,
  parameter int     TICK_FAST = dai_pkg::TICK_FAST_CYC,
  parameter int     FILT_STEP = dai_pkg::FILT_STEP_CYC,
  parameter longint GATE      = dai_pkg::PI_GATE,
  parameter longint HALF      = dai_pkg::PO_HALF
) (
  // APB
  input  logic                      pclk,
  input  logic                      presetn,
  input  logic                      psel,
  input  logic                      penable,
  input  logic                      pwrite,
  input  logic [11:0]               paddr,
  input  logic [31:0]               pwdata,
  input  logic [3:0]                pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Pins
  input  logic                      pulse_in_terminal,
  input  logic [7:0]                multi_function_input,
  output logic                      pulse_out_terminal,
  output logic                      timer_relay_out,
  // Drive state, same clock
  input  logic                      run_status,
  input  logic signed [15:0]        out_freq_pct,
  input  logic signed [15:0]        torque_pct,
  input  logic [11:0]               analog_in_one,
  input  logic [11:0]               analog_in_two,
  // Results
  output logic signed [15:0]        freq_ref_pct,
  output dai_pkg::dai_flags_t       flags,
  output logic                      updown_ramp2,
  output dai_pkg::dai_ain_mode_t    ain1_mode,
  output logic                      ain2_current,
  output logic [4:0]                ain2_func,
  output logic signed [15:0]        ain2_level
);
  import dai_pkg::*;

  // Pin synchronisers, pulse input at bit 8
  logic [8:0] pin_s1_q;
  logic [8:0] pin_s2_q;
  logic       pi_s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pi_s3_q  <= 1'b0;
    end else begin
      pin_s1_q <= {pulse_in_terminal, multi_function_input};
      pin_s2_q <= pin_s1_q;
      pi_s3_q  <= pin_s2_q[8];
    end
  end
  wire [7:0] mfi     = pin_s2_q[7:0];
  wire       pi_rise = pin_s2_q[8] & ~pi_s3_q;

  // APB decode
  logic [15:0] cfg_q [NUM_CFG];
  logic [15:0] ro_word;
  wire  [4:0]  ix      = paddr[6:2];
  wire         in_map  = (paddr[11:7] == 5'h00);
  wire         cfg_hit = in_map && (ix < 5'(NUM_CFG));
  wire         ro_hit  = in_map && (ix >= IX_STATUS);
  wire  [4:0]  cfg_ix  = cfg_hit ? ix : 5'h00;
  wire         setup   = psel & ~penable;
  wire         bad_wr  = pwrite & (ro_hit | (pstrb[1:0] != 2'h3));
  wire         refuse  = ~(cfg_hit | ro_hit) | bad_wr;
  wire         wr_fire = psel & penable & pready & pwrite &
                         ~pslverr;

  // Writes are clamped into each register's legal range
  wire dai_lim_t wr_raw = CFG_SGN[cfg_ix] ?
                          {pwdata[15], pwdata[15:0]} :
                          {1'b0, pwdata[15:0]};
  wire dai_lim_t wr_lim =
    (wr_raw < CFG_MIN[cfg_ix]) ? CFG_MIN[cfg_ix] :
    (wr_raw > CFG_MAX[cfg_ix]) ? CFG_MAX[cfg_ix] : wr_raw;

  for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_q[i] <= CFG_RST[i][15:0];
      end else if (wr_fire && cfg_ix == 5'(i)) begin
        cfg_q[i] <= wr_lim[15:0]; // see R8 see R16 see R17 see R21
      end
    end
  end

  wire [15:0] rd_word = cfg_hit ? cfg_q[cfg_ix] : ro_word;

  // Zero-wait answer: pready rises in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & refuse;
      prdata  <= (setup && !pwrite && !refuse) ?
                 {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  // Settings
  wire [2:0]  ref_src  = cfg_q[IX_REF_SRC][2:0];
  wire [1:0]  pi_func  = cfg_q[IX_PI_FUNC][1:0];
  wire [15:0] pi_scale = cfg_q[IX_PI_SCALE];
  wire [15:0] pi_gain  = cfg_q[IX_PI_GAIN];
  wire signed [15:0] pi_bias = cfg_q[IX_PI_BIAS];
  wire [2:0]  po_func  = cfg_q[IX_PO_FUNC][2:0];
  wire [15:0] po_scale = cfg_q[IX_PO_SCALE];
  wire [2:0]  ain_type = cfg_q[IX_AIN_TYPE][2:0];
  wire        neg_char = cfg_q[IX_NEG_CHAR][0];
  wire [4:0]  a2_func  = cfg_q[IX_A2_FUNC][4:0];

  // Function decode of the eight inputs
  logic [7:0] sync_hit;
  logic [7:0] tmr_hit;
  for (genvar i = 0; i < 8; i++) begin : g_mfi
    wire [7:0] code = cfg_q[IX_MFI0 + 5'(i / 2)][8 * (i % 2) +: 8];
    assign sync_hit[i] = (code == MFI_SYNC) & mfi[i]; // see R7
    assign tmr_hit[i]  = (code == MFI_TIMER);
  end
  wire tmr_en = (|tmr_hit) &&
                (cfg_q[IX_MFO_FUNC][7:0] == MFO_TIMER); // see R9
  wire tmr_in = tmr_en && |(tmr_hit & mfi);

  // Tick generators for the delay timers
  logic [31:0] slow_cnt_q;
  logic [31:0] fast_cnt_q;
  wire slow_tick = (slow_cnt_q == 32'(TICK_SLOW - 1));
  wire fast_tick = (fast_cnt_q == 32'(TICK_FAST - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt_q <= '0;
      fast_cnt_q <= '0;
    end else begin
      slow_cnt_q <= slow_tick ? 32'h0 : slow_cnt_q + 32'h1;
      fast_cnt_q <= fast_tick ? 32'h0 : fast_cnt_q + 32'h1;
    end
  end

  // Pulse input: a gate of GATE/scale clocks counts 0.1 % per edge,
  // so no divider is needed; long gates for low scales are the cost
  logic [36:0]        gate_q;
  logic [19:0]        pi_cnt_q;
  logic signed [15:0] pi_pct_q;
  wire [36:0] gate_nx   = gate_q + 37'(pi_scale);
  wire        gate_done = gate_nx >= 37'(GATE);
  wire [19:0] cnt_inc   = (&pi_cnt_q) ? pi_cnt_q : pi_cnt_q + 20'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q   <= '0;
      pi_cnt_q <= '0;
      pi_pct_q <= '0;
    end else if (gate_done) begin
      gate_q   <= '0;
      pi_cnt_q <= {19'h0, pi_rise};
      pi_pct_q <= (pi_cnt_q > 20'h07FFF) ? PCT_MAX :
                  $signed(pi_cnt_q[15:0]); // see R4
    end else begin
      gate_q   <= gate_nx;
      pi_cnt_q <= pi_rise ? cnt_inc : pi_cnt_q;
    end
  end

  wire signed [33:0] pi_prod = $signed({1'b0, pi_pct_q[15:0]}) *
                               $signed({18'h0, pi_gain}); // see R5
  wire signed [47:0] pi_sum  = 48'(pi_prod / GAIN_ONE) +
                               48'(pi_bias); // see R6
  wire signed [15:0] pi_ref  = sat_pct(pi_sum); // see R24
  wire               pi_ok   = (pi_func == PI_GENERAL); // see R3

  // Analog inputs: normalise to Q12 of full scale
  function automatic logic signed [13:0] ain_norm(
      input logic [11:0]   adc,
      input dai_ain_mode_t mode,
      input logic          neg);
    logic signed [13:0] v;
    logic signed [13:0] x;
    v = $signed({2'b00, adc});
    x = v;
    case (mode)
      AIN_V_BI:   x = 14'((v - ADC_MID) * 2);
      AIN_I_4_20: x = (v < ADC_4MA) ? 14'sh0000 :
                      14'(((v - ADC_4MA) * 5) >>> 2);
      default:    x = v;
    endcase
    if (neg) begin
      x = (mode == AIN_V_BI) ? -x : AIN_FS - x; // see R23
    end
    return x;
  endfunction

  // Level = bias + (gain - bias) * fraction of full scale
  function automatic logic signed [15:0] ain_scale(
      input logic [15:0]        gain,
      input logic signed [15:0] bias,
      input logic signed [13:0] x);
    logic signed [17:0] span;
    logic signed [47:0] prod;
    span = $signed({2'b00, gain}) - 18'(bias); // see R18 see R19
    prod = 48'(span) * 48'(x);
    return sat_pct((prod >>> AIN_QB) + 48'(bias)); // see R24
  endfunction

  wire dai_ain_mode_t a1_mode = dai_ain_mode_t'(2'(ain_type >> 1));
  wire dai_ain_mode_t a2_mode = ain_type[0] ? AIN_I_4_20 : AIN_V_UNI;
  wire signed [13:0] a1_x = ain_norm(analog_in_one, a1_mode, neg_char);
  wire signed [13:0] a2_x = ain_norm(analog_in_two, a2_mode, neg_char);
  wire signed [15:0] a1_raw = ain_scale(cfg_q[IX_A1_GAIN],
                                        cfg_q[IX_A1_BIAS], a1_x);
  wire signed [15:0] a2_raw = ain_scale(cfg_q[IX_A2_GAIN],
                                        cfg_q[IX_A2_BIAS], a2_x);
  wire signed [15:0] a1_pct;
  wire signed [15:0] a2_pct;

  dai_lpf #(.STEP_CYC(FILT_STEP), .TW(8)) u_lpf1 (
    .pclk    (pclk),
    .presetn (presetn),
    .tau     (cfg_q[IX_A1_FILT][7:0]),
    .x       (a1_raw),
    .y       (a1_pct)
  );

  dai_lpf #(.STEP_CYC(FILT_STEP), .TW(8)) u_lpf2 (
    .pclk    (pclk),
    .presetn (presetn),
    .tau     (cfg_q[IX_A2_FILT][7:0]),
    .x       (a2_raw),
    .y       (a2_pct)
  );

  // Reference selection
  wire signed [15:0] ain_ref = (a2_func == AIN2_ADD) ?
                               sat_pct(48'(a1_pct) + 48'(a2_pct)) :
                               a1_pct; // see R20
  wire signed [15:0] ref_d =
    (ref_src == REF_ANALOG) ? ain_ref :
    (ref_src == REF_PULSE && pi_ok) ? pi_ref : 16'sh0000; // see R1

  // Pulse output: accumulator toggles every HALF units
  wire signed [15:0] po_src =
    (po_func == PO_OUT_FREQ) ? out_freq_pct :
    (po_func == PO_FREQ_CMD) ? freq_ref_pct : 16'sh0000; // see R2
  wire [30:0] po_rate = po_src[15] ? 31'h0 :
                        31'(po_scale) * 31'(po_src[14:0]);
  logic [36:0] nco_q;
  wire  [36:0] nco_nx  = nco_q + 37'(po_rate);
  wire         nco_hit = nco_nx >= 37'(HALF);

  // Brake release condition
  wire signed [16:0] trq_lvl = 17'(cfg_q[IX_TRQ_LVL] * 16'(TRQ_UNIT));
  wire brk_cond = run_status &&
                  (out_freq_pct > $signed(cfg_q[IX_FDET_LVL])) &&
                  (17'(torque_pct) > trq_lvl); // see R12
  wire tmr_out;
  wire brk_out;

  dai_delay_timer #(.W(16)) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (slow_tick),
    .on_dly  (cfg_q[IX_TMR_ON]),
    .off_dly (cfg_q[IX_TMR_OFF]),
    .din     (tmr_in),
    .dout_q  (tmr_out)
  );

  dai_delay_timer #(.W(16)) u_brk (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (fast_tick),
    .on_dly  (cfg_q[IX_BRK_DLY]),
    .off_dly (16'h0000),
    .din     (brk_cond),
    .dout_q  (brk_out)
  );

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_q              <= '0;
      pulse_out_terminal <= 1'b0;
      timer_relay_out    <= 1'b0;
      freq_ref_pct       <= '0;
      flags              <= '0;
      updown_ramp2       <= 1'b0;
      ain1_mode          <= AIN_V_UNI;
      ain2_current       <= 1'b0;
      ain2_func          <= AIN2_AUX;
      ain2_level         <= '0;
    end else begin
      nco_q              <= nco_hit ? nco_nx - 37'(HALF) : nco_nx;
      pulse_out_terminal <= pulse_out_terminal ^ nco_hit; // see R2
      timer_relay_out    <= tmr_out & tmr_en; // see R9
      freq_ref_pct       <= ref_d;
      flags.sync         <= |sync_hit; // see R7
      flags.timer        <= tmr_out & tmr_en;
      flags.brake        <= brk_out; // see R12
      flags.pulse_ok     <= pi_ok;
      flags.therm        <= (a2_func == AIN2_THERM) &&
                            (a2_pct > THERM_TRIP); // see R20
      updown_ramp2       <= cfg_q[IX_UPDN_SEL][0]; // see R14
      ain1_mode          <= a1_mode; // see R15
      ain2_current       <= a2_mode == AIN_I_4_20;
      ain2_func          <= a2_func;
      ain2_level         <= a2_pct;
    end
  end

  assign ro_word = (ix == IX_STATUS)   ? {11'h000, flags} :
                   (ix == IX_PI_PCT)   ? pi_pct_q :
                   (ix == IX_AIN1_PCT) ? a1_pct :
                   (ix == IX_FREQ_REF) ? freq_ref_pct : 16'h0000;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_brk_low2;
    !brk_cond [*2];
  endsequence

  a_ref_pulse_pick: assert property ( // see R1
    ref_src == REF_PULSE && pi_func == PI_GENERAL
    |=> freq_ref_pct == $past(pi_ref))
    else $error("pulse reference not selected");
  a_ref_analog_pick: assert property ( // see R1
    ref_src == REF_ANALOG |=> freq_ref_pct == $past(ain_ref))
    else $error("analog reference not selected");
  a_po_idle_hold: assert property ( // see R2
    po_func != PO_OUT_FREQ && po_func != PO_FREQ_CMD
    ##1 po_func != PO_OUT_FREQ && po_func != PO_FREQ_CMD
    |=> $stable(pulse_out_terminal))
    else $error("pulse output toggled with no source");
  a_sync_decode: assert property ( // see R7
    ##1 flags.sync == $past(|sync_hit))
    else $error("sync command mismatch");
  a_timer_gate: assert property ( // see R9
    !tmr_en |=> !timer_relay_out)
    else $error("timer output without assignment");
  a_delay_range: assert property ( // see R8
    cfg_q[IX_TMR_ON] <= 16'hEA60 && cfg_q[IX_TMR_OFF] <= 16'hEA60)
    else $error("timer delay out of range");
  a_ref_saturate: assert property ( // see R24
    freq_ref_pct != 16'sh8000)
    else $error("reference wrapped past full scale");
  a_brake_drop: assert property ( // see R12
    s_brk_low2 |=> !flags.brake)
    else $error("brake held released without condition");
  a_ain_type_map: assert property ( // see R15
    ##1 ain1_mode == $past(dai_ain_mode_t'(2'(ain_type >> 1)))
    && ain2_current == $past(ain_type[0]))
    else $error("analog type decode wrong");
endmodule // dai_top

// ===== dai_top_tb.sv
`timescale 1ns/1ps
module dai_top_tb;
  import dai_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready;
  logic               pslverr, pen, pin, tro, run, e, a2c, po, ud;
  logic [3:0]         ps;
  logic [11:0]        paddr, a1, a2;
  logic [31:0]        pwdata, prdata, r;
  logic [7:0]         mfi;
  logic signed [15:0] ofr, trq, fref, a2l;
  dai_flags_t         flg;
  dai_ain_mode_t      m1;
  int                 error_cnt, check_count, g, b, k, tg, seed = 32'h3750;
  dai_top #(.TICK_SLOW(10), .TICK_FAST(5), .FILT_STEP(2), .GATE(20000),
    .HALF(2_000_000)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(ps), .prdata, .pready, .pslverr,
    .pulse_in_terminal(pin), .multi_function_input(mfi),
    .pulse_out_terminal(po), .timer_relay_out(tro), .run_status(run),
    .out_freq_pct(ofr), .torque_pct(trq), .analog_in_one(a1),
    .analog_in_two(a2), .freq_ref_pct(fref), .flags(flg),
    .updown_ramp2(ud), .ain1_mode(m1), .ain2_current(a2c), .ain2_func(),
    .ain2_level(a2l));
  always @(po) tg++;
  dai_pgen PGEN (.pclk, .en(pen), .pin);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] s, x, input string n);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] %s exp %0d seen %0d", n, x, s);
    end
  endtask
  function automatic logic nr(input logic signed [16:0] s, x, input int t);
    return s - x <= t && x - s <= t;
  endfunction
  // One pulse per four clocks over a gate of GATE/scale clocks, 0.1 % units
  function automatic int pi_exp(input int sc);
    return 20000 / (4 * sc);
  endfunction
  // Toggles in n clocks at the reset scale of 1000 over the half step
  function automatic int po_exp(input int n, src);
    return n * 1000 * src / 2_000_000;
  endfunction
  task automatic apb(input logic w, input logic [4:0] ix, input int d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {5'h00, ix, 2'h0};
    pwdata <= {16'h0000, 16'(d)};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us error_cnt++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, pen, run, mfi, a1, a2, paddr, pwdata,
     ofr, trq} = '0;
    ps = 4'hF;
    tk(4);
    presetn <= 1'b1;
    apb(0, IX_PI_SCALE, 0);
    chk(r, 1000, "pi_scale");
    apb(0, 5'h1B, 0);
    chk(e, 1, "unmapped");
    for (k = 0; k < 6; k++) begin
      apb(1, IX_AIN_TYPE, k);
      tk(3);
      chk(m1, k / 2, "ain1_mode");
      chk(a2c, k % 2, "ain2_cur");
    end
    a1 <= 12'($random(seed));
    a2 <= 12'($random(seed));
    apb(1, IX_AIN_TYPE, 0);
    apb(0, IX_AIN1_PCT, 0);
    chk(nr(r[15:0], a1 * 1000 / 4095, 1), 1, "ain1_pct");
    chk(nr(a2l, a2 * 1000 / 4095, 1), 1, "ain2_level");
    apb(1, IX_NEG_CHAR, 1);
    apb(0, IX_AIN1_PCT, 0);
    chk(nr(r[15:0], (4095 - a1) * 1000 / 4095, 1), 1, "ain1_neg");
    apb(1, IX_REF_SRC, 4);
    apb(1, IX_PI_SCALE, 100);
    g = 500 + $unsigned($random(seed)) % 1501;
    b = $random(seed) % 101;
    apb(1, IX_PI_GAIN, g);
    ps <= 4'h0;
    apb(1, IX_PI_GAIN, 0);
    chk(e, 1, "strb_refused");
    ps <= 4'hF;
    apb(0, IX_PI_GAIN, 0);
    chk(r, g, "pi_gain");
    apb(1, IX_PI_BIAS, b);
    pen <= 1'b1;
    // Two whole gates of 200 clocks; one pulse of slack per gate
    tk(500);
    apb(0, IX_PI_PCT, 0);
    chk(nr(r[15:0], pi_exp(100), 1), 1, "pulse_pct");
    k = pi_exp(100) * g / 1000 + b;
    chk(nr(fref, k, 3), 1, "pulse_ref");
    k = 1 + $unsigned($random(seed)) % 7;
    apb(1, 5'(IX_MFI0 + k / 2), MFI_SYNC << 8 * (k % 2));
    mfi <= 8'(1 << k);
    tk(5);
    chk(flg.sync, 1, "sync");
    apb(1, IX_TMR_ON, 2);
    apb(1, IX_TMR_OFF, 3);
    apb(1, IX_MFO_FUNC, MFO_TIMER);
    apb(1, IX_MFI0, MFI_TIMER);
    mfi <= 8'h01;
    tk(5);
    chk(tro, 0, "tmr_early");
    tk(30);
    chk(tro, 1, "tmr_on");
    mfi <= 8'h00;
    tk(5);
    chk(tro, 1, "tmr_hold");
    tk(40);
    chk(tro, 0, "tmr_off");
    // Brake runs without the frequency lock, which is only advised
    apb(1, IX_BRK_DLY, 2);
    {run, ofr, trq} <= {1'b1, 16'sd500, 16'sd500};
    tk(3);
    chk(flg.brake, 0, "brk_early");
    tk(25);
    chk(flg.brake, 1, "brk_rel");
    tg = 0;
    tk(80);
    chk(nr(tg, po_exp(80, 500), 2), 1, "po_toggles");
    apb(1, IX_PO_FUNC, 0);
    tk(2);
    tg = 0;
    tk(20);
    chk(tg, 0, "po_idle");
    apb(1, IX_UPDN_SEL, 1);
    tk(2);
    chk(ud, 1, "updown");
    finish_test();
  end
endmodule // dai_top_tb
